// File: pvp_defines.svh
`ifndef PVP_DEFINES_SVH
`define PVP_DEFINES_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PVP_OFS_CTRL   8'h00
`define PVP_OFS_DELAY  8'h04
`define PVP_OFS_COUNT  8'h08
`define PVP_OFS_LINES  8'h0C
`define PVP_OFS_STAT   8'h10
// ****************************************
// Control field positions
// ****************************************
`define PVP_EN_BIT     0
`define PVP_MODE_LSB   1
`define PVP_WLEN_LSB   4
`define PVP_VID10_BIT  8
`define PVP_NSYNC_LSB  9
`define PVP_CTRL_W     11
// ****************************************
// Status field positions
// ****************************************
`define PVP_ST_OVF_BIT 0
`define PVP_ST_UDR_BIT 1
`define PVP_ST_LCK_BIT 2
`define PVP_ST_FLD_BIT 3
`define PVP_ST_FSM_LSB 4
// ****************************************
// Reset values and code words
// ****************************************
`define PVP_CTRL_RST   11'h000
`define PVP_DELAY_RST  16'h0000
`define PVP_COUNT_RST  16'h0001
`define PVP_LINES_RST  16'h0001
`define PVP_CODE_ONES  8'hFF
`define PVP_CODE_ZERO  8'h00
`define PVP_RESP_OKAY  2'h0
`define PVP_RESP_ERR   2'h2
`endif

// File: pvp_pkg.sv
package pvp_pkg;
	// ****************************************
	// Operating submodes
	// ****************************************
	typedef enum logic [2:0] {
		MODE_GP_IN  = 3'h0,
		MODE_GP_CAP = 3'h1,
		MODE_GP_OUT = 3'h2,
		MODE_V_ACT  = 3'h3,
		MODE_V_VBI  = 3'h4,
		MODE_V_FLD  = 3'h5
	} mode_t;
	// Gray order: idle, wait, transfer
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h1,
		ST_XFER = 2'h3
	} gp_state_t;
	// One captured video word with its keep mark
	typedef struct packed {
		logic [15:0] data;
		logic        keep;
	} vid_word_t;
endpackage : pvp_pkg

// File: pvp_sync2.sv
`timescale 1ns/10ps
// ****************************************
// Two-flop synchroniser
// ****************************************
module pvp_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;
	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : pvp_sync2

// File: pvp_fifo.sv
`timescale 1ns/10ps
// ****************************************
// Small sample buffer, DEPTH a power of two
// ****************************************
module pvp_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 4
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic      [W-1:0] out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0]   cnt_q;
	logic          push, pop;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rp_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage needs no reset; emptiness is in cnt_q
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	// Pointers wrap naturally at the power-of-two depth
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule : pvp_fifo

// File: parallel_video_port.sv
// Functional notes
// - Port clock sampled; rate at most half system
// - One clock, three syncs, sixteen data pins
// - Each frame sync configurable input or output
// - General-purpose data bus half-duplex, sixteen bits
// - Video mode carries 8 or 10 bits
// - Embedded line and field codes decoded
// - Submode sets sync and data directions
// - Programmable port-clock delay before reading data
// - Exactly programmed sample count per sync
// - Width 8 or 10 to 16 bits
// - Capture drives horizontal and vertical syncs
// - Output drives data with 1-3 syncs
// - Active mode drops blanking and code words
// - After field lock wait for active start
// - Active mode count gives lines per frame
// - Blanking mode keeps only vertical blanking
// - Entire field passes every sample
// - Entire field starts right at field lock
`timescale 1ns/10ps
`include "pvp_defines.svh"
module parallel_video_port
	import pvp_pkg::*;
#(
	parameter int CNT_W = 16,
	parameter int DEPTH = 4
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic      [1:0]  bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic      [31:0] rdata,
	output logic      [1:0]  rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        port_sample_clock,
	input  wire logic [2:0]  frame_sync_in,
	output logic      [2:0]  frame_sync_out,
	output logic      [2:0]  frame_sync_oe,
	input  wire logic [15:0] port_data_in,
	output logic      [15:0] port_data_out,
	output logic             port_data_oe,
	output logic      [15:0] rx_data,
	output logic             rx_valid,
	input  wire logic        rx_ready,
	input  wire logic [15:0] tx_data,
	input  wire logic        tx_valid,
	output logic             tx_ready,
	output logic             field_lock
);
	// ****************************************
	// Register bus slave
	// ****************************************
	logic [`PVP_CTRL_W-1:0] ctrl_q;
	logic [CNT_W-1:0]       delay_q, count_q, lines_q;
	logic                   aw_q, w_q, wr_go, wr_hit;
	logic [7:0]             awaddr_q, wa, ra;
	logic [31:0]            wdata_q, rd_d, stat_w;
	logic [3:0]             wstrb_q;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	assign awready = !aw_q;
	assign wready  = !w_q;
	assign arready = !rvalid;
	assign wr_go   = aw_q & w_q & !bvalid;
	assign wa      = {awaddr_q[7:2], 2'b00};
	assign ra      = {araddr[7:2], 2'b00};
	assign wr_hit  = (wa == `PVP_OFS_CTRL) || (wa == `PVP_OFS_DELAY) ||
		(wa == `PVP_OFS_COUNT) || (wa == `PVP_OFS_LINES) || (wa == `PVP_OFS_STAT);

	// Address and data taken in either order; answer follows both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q     <= 1'b0;
			w_q      <= 1'b0;
			bvalid   <= 1'b0;
			bresp    <= `PVP_RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_q     <= 1'b1;
				awaddr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_q     <= 1'b1;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (wr_go) begin
				aw_q   <= 1'b0;
				w_q    <= 1'b0;
				bvalid <= 1'b1;
				bresp  <= wr_hit ? `PVP_RESP_OKAY : `PVP_RESP_ERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Setting registers, byte strobes honoured
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q  <= `PVP_CTRL_RST;
			delay_q <= CNT_W'(`PVP_DELAY_RST);
			count_q <= CNT_W'(`PVP_COUNT_RST);
			lines_q <= CNT_W'(`PVP_LINES_RST);
		end else if (wr_go) begin
			case (wa)
				`PVP_OFS_CTRL: ctrl_q <=
					`PVP_CTRL_W'(merge(32'(ctrl_q), wdata_q, wstrb_q));
				`PVP_OFS_DELAY: delay_q <= CNT_W'(merge(32'(delay_q), wdata_q, wstrb_q));
				`PVP_OFS_COUNT: count_q <= CNT_W'(merge(32'(count_q), wdata_q, wstrb_q));
				`PVP_OFS_LINES: lines_q <= CNT_W'(merge(32'(lines_q), wdata_q, wstrb_q));
				default: ;
			endcase
		end
	end

	// Read mux; unmapped reads return zero with an error
	always_comb begin
		case (ra)
			`PVP_OFS_CTRL:  rd_d = 32'(ctrl_q);
			`PVP_OFS_DELAY: rd_d = 32'(delay_q);
			`PVP_OFS_COUNT: rd_d = 32'(count_q);
			`PVP_OFS_LINES: rd_d = 32'(lines_q);
			`PVP_OFS_STAT:  rd_d = stat_w;
			default:        rd_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= `PVP_RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= rd_d;
			rresp  <= (ra > `PVP_OFS_STAT) ? `PVP_RESP_ERR : `PVP_RESP_OKAY;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ****************************************
	// Control decode
	// ****************************************
	mode_t     mode;
	logic      en, vid10, gp_on, vid_on, fs_drive;
	logic [3:0] wlen;
	logic [1:0] nsync;
	logic [15:0] wmask;

	assign en     = ctrl_q[`PVP_EN_BIT];
	assign mode   = mode_t'(ctrl_q[`PVP_MODE_LSB +: 3]);
	assign wlen   = ctrl_q[`PVP_WLEN_LSB +: 4];
	assign vid10  = ctrl_q[`PVP_VID10_BIT];
	assign nsync  = ctrl_q[`PVP_NSYNC_LSB +: 2];
	assign gp_on  = en & (mode == MODE_GP_IN || mode == MODE_GP_CAP || mode == MODE_GP_OUT);
	assign vid_on = en & (mode == MODE_V_ACT || mode == MODE_V_VBI || mode == MODE_V_FLD);
	assign fs_drive = en & (mode == MODE_GP_CAP || mode == MODE_GP_OUT);
	// Width code holds width minus one: 7 or 9 to 15
	assign wmask  = 16'hFFFF >> (4'hF - wlen);

	// ****************************************
	// Pin synchronisers and port clock edges
	// ****************************************
	logic [19:0] syn_w;
	logic        pclk_q, pclk_rise, fs1_q;
	logic [2:0]  fs_s;
	logic [15:0] din_s;

	// Clock, syncs and data share one delay so they stay aligned
	pvp_sync2 #(.WIDTH(20)) u_sync (
		.clk   (aclk),
		.rst_n (aresetn),
		.d     ({port_sample_clock, frame_sync_in, port_data_in}),
		.q     (syn_w)
	);
	assign fs_s  = syn_w[18:16];
	assign din_s = syn_w[15:0];
	// Rate at or below half the system clock keeps edges apart
	assign pclk_rise = syn_w[19] & ~pclk_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pclk_q <= 1'b0;
			fs1_q  <= 1'b0;
		end else begin
			pclk_q <= syn_w[19];
			if (pclk_rise) begin
				fs1_q <= fs_s[0];
			end
		end
	end

	// ****************************************
	// General-purpose engine
	// ****************************************
	gp_state_t state_q;
	logic [CNT_W-1:0] dcnt_q, scnt_q, line_q;
	logic trig, xfer_edge;

	// Input submode waits on the source's first sync; others self-start
	assign trig = (mode == MODE_GP_IN) ? (fs_s[0] & ~fs1_q) : 1'b1;
	assign xfer_edge = gp_on & pclk_rise & (state_q == ST_XFER);

	always_ff @(posedge aclk) begin
		if (!aresetn || !gp_on) begin
			state_q <= ST_IDLE;
			dcnt_q  <= '0;
			scnt_q  <= '0;
		end else if (pclk_rise) begin
			case (state_q)
				ST_IDLE: if (trig) begin
					dcnt_q  <= '0;
					scnt_q  <= '0;
					state_q <= (delay_q == '0) ? ST_XFER : ST_WAIT;
				end
				ST_WAIT: begin
					dcnt_q <= dcnt_q + 1'b1;
					if (dcnt_q == delay_q - 1'b1) begin
						state_q <= ST_XFER;
					end
				end
				ST_XFER: begin
					scnt_q <= scnt_q + 1'b1;
					if (scnt_q == count_q - 1'b1) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Line counter frames the generated vertical sync
	always_ff @(posedge aclk) begin
		if (!aresetn || !fs_drive) begin
			line_q <= '0;
		end else if (xfer_edge && scnt_q == count_q - 1'b1) begin
			line_q <= (line_q + 1'b1 >= lines_q) ? '0 : line_q + 1'b1;
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	logic out_mode, udr_set;

	assign out_mode = en & (mode == MODE_GP_OUT);
	// Data bus drives only in output submode, so never both ways
	assign port_data_oe = out_mode;
	// Sync directions per submode and sync count
	always_comb begin
		if (en && mode == MODE_GP_CAP) begin
			frame_sync_oe = 3'h3;
		end else if (out_mode) begin
			frame_sync_oe = (nsync == 2'h3) ? 3'h7 : (nsync == 2'h2) ? 3'h3 : 3'h1;
		end else begin
			frame_sync_oe = 3'h0;
		end
	end
	// Memory side offers a word; taken once per output sample
	assign tx_ready = out_mode & xfer_edge;
	assign udr_set  = tx_ready & !tx_valid;

	// Horizontal sync outside transfer, vertical on line zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frame_sync_out <= 3'h0;
			port_data_out  <= 16'h0000;
		end else begin
			frame_sync_out[0] <= fs_drive & (state_q != ST_XFER);
			frame_sync_out[1] <= fs_drive & (line_q == '0);
			frame_sync_out[2] <= out_mode & (state_q != ST_XFER) & (line_q == '0);
			if (tx_ready) begin
				port_data_out <= tx_valid ? (tx_data & wmask) : 16'h0000;
			end
		end
	end

	// ****************************************
	// Embedded-sync video decode
	// ****************************************
	vid_word_t pipe_q [4];
	vid_word_t new_w;
	logic [7:0] vw, n0, n1, n2;
	logic       vid_edge, is_xy, kill, keep_new;
	logic       lock_q, act_q, vbl_q, fprev_q;
	logic [CNT_W-1:0] lcnt_q;

	function automatic logic [7:0] norm(input logic [15:0] d, input logic w10);
		return w10 ? d[9:2] : d[7:0];
	endfunction : norm

	assign vid_edge = vid_on & pclk_rise;
	assign vw = norm(din_s, vid10);
	assign n0 = norm(pipe_q[0].data, vid10);
	assign n1 = norm(pipe_q[1].data, vid10);
	assign n2 = norm(pipe_q[2].data, vid10);
	// Status word after all-ones, zero, zero
	assign is_xy = vid_edge & (n2 == `PVP_CODE_ONES) & (n1 == `PVP_CODE_ZERO) &
		(n0 == `PVP_CODE_ZERO);
	// Entire field keeps codes; other modes strip all four words
	assign kill = is_xy & (mode != MODE_V_FLD);
	always_comb begin
		case (mode)
			MODE_V_FLD: keep_new = lock_q;
			MODE_V_ACT: keep_new = lock_q & act_q;
			MODE_V_VBI: keep_new = lock_q & vbl_q;
			default:    keep_new = 1'b0;
		endcase
	end
	// Width 8 or 10 bits zero-padded
	assign new_w = '{data: vid10 ? {6'h00, din_s[9:0]} : {8'h00, din_s[7:0]},
		keep: keep_new & ~kill};

	// Four-word delay lets a late-found code be dropped whole
	// Cleared while video is off, so no stale word leaks into the next run
	always_ff @(posedge aclk) begin
		if (!aresetn || !vid_on) begin
			pipe_q[0] <= '0;
		end else if (vid_edge) begin
			pipe_q[0] <= new_w;
		end
	end
	for (genvar i = 1; i < 4; i++) begin : g_pipe
		always_ff @(posedge aclk) begin
			if (!aresetn || !vid_on) begin
				pipe_q[i] <= '0;
			end else if (vid_edge) begin
				pipe_q[i] <= '{data: pipe_q[i-1].data,
					keep: pipe_q[i-1].keep & ~(kill && i < 4)};
			end
		end
	end

	// Field lock on field bit falling to field 1; lines counted
	always_ff @(posedge aclk) begin
		if (!aresetn || !vid_on) begin
			lock_q  <= 1'b0;
			act_q   <= 1'b0;
			vbl_q   <= 1'b0;
			fprev_q <= 1'b0;
			lcnt_q  <= '0;
		end else if (is_xy) begin
			fprev_q <= vw[6];
			vbl_q   <= vw[5];
			if (!vw[6] && fprev_q) begin
				lock_q <= 1'b1;
				act_q  <= 1'b0;
				lcnt_q <= '0;
			end else if (lock_q) begin
				act_q <= ~vw[4] & ~vw[5];
				if (mode == MODE_V_ACT && vw[4] && act_q) begin
					lcnt_q <= lcnt_q + 1'b1;
					if (lcnt_q == count_q - 1'b1) begin
						lock_q <= 1'b0;
					end
				end
			end
		end
	end
	assign field_lock = lock_q;

	// ****************************************
	// Sample buffer and status
	// ****************************************
	logic [15:0] push_d;
	logic        push_v, push_rdy, gp_cap, ovf_q, udr_q, stat_wr;

	assign gp_cap = xfer_edge & (mode != MODE_GP_OUT);
	assign push_v = gp_cap | (vid_edge & pipe_q[3].keep);
	assign push_d = gp_cap ? (din_s & wmask) : pipe_q[3].data;

	pvp_fifo #(.W(16), .DEPTH(DEPTH)) u_fifo (
		.clk       (aclk),
		.rst_n     (aresetn),
		.in_data   (push_d),
		.in_valid  (push_v),
		.in_ready  (push_rdy),
		.out_data  (rx_data),
		.out_valid (rx_valid),
		.out_ready (rx_ready)
	);

	// Sticky flags; a new event beats a same-cycle clear
	assign stat_wr = wr_go & (wa == `PVP_OFS_STAT) & wstrb_q[0];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovf_q <= 1'b0;
			udr_q <= 1'b0;
		end else begin
			ovf_q <= (push_v & ~push_rdy) |
				(ovf_q & ~(stat_wr & wdata_q[`PVP_ST_OVF_BIT]));
			udr_q <= udr_set | (udr_q & ~(stat_wr & wdata_q[`PVP_ST_UDR_BIT]));
		end
	end
	always_comb begin
		stat_w = 32'h0000_0000;
		stat_w[`PVP_ST_OVF_BIT] = ovf_q;
		stat_w[`PVP_ST_UDR_BIT] = udr_q;
		stat_w[`PVP_ST_LCK_BIT] = lock_q;
		stat_w[`PVP_ST_FLD_BIT] = fprev_q;
		stat_w[`PVP_ST_FSM_LSB +: 2] = state_q;
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	rate_edge_a: assert property (pclk_rise |=> !pclk_rise)
		else $error("port clock edge seen on adjacent cycles");
	input_dirs_a: assert property (en && mode == MODE_GP_IN |->
		frame_sync_oe == 3'h0 && !port_data_oe)
		else $error("input submode drives a pin");
	capture_dirs_a: assert property (en && mode == MODE_GP_CAP |->
		frame_sync_oe == 3'h3 && !port_data_oe)
		else $error("capture submode pin directions wrong");
	out_syncs_a: assert property (out_mode && nsync == 2'h2 |->
		frame_sync_oe == 3'h3 && port_data_oe)
		else $error("output submode sync enables wrong");
	delay_hold_a: assert property (gp_on && state_q == ST_WAIT && pclk_rise &&
		dcnt_q != delay_q - 1'b1 |=> state_q == ST_WAIT)
		else $error("wait left before delay ran out");
	count_end_a: assert property (xfer_edge && scnt_q == count_q - 1'b1 &&
		gp_on |=> state_q == ST_IDLE)
		else $error("transfer passed the programmed count");
	width_mask_a: assert property (gp_cap |-> (push_d & ~wmask) == 16'h0000)
		else $error("sample bits above width");
	half_duplex_a: assert property (port_data_oe |-> !gp_cap ##1 !gp_cap)
		else $error("capture while driving the bus");
	code_strip_a: assert property (kill |=> !pipe_q[1].keep && !pipe_q[2].keep &&
		!pipe_q[3].keep)
		else $error("code word kept in stripping mode");
	lock_wait_a: assert property ($rose(lock_q) |-> !act_q)
		else $error("active video before start code");
endmodule : parallel_video_port

// File: pvp_source_model.sv
`timescale 1ns/10ps
// ****************************************
// Parallel sample source on the far side
// ****************************************
module pvp_source_model (
	input  wire logic        go,
	input  wire logic        vid,
	input  wire logic [7:0]  edges,
	input  wire logic [15:0] base,
	output logic             port_clk,
	output logic [2:0]       fs,
	output logic [15:0]      data,
	output logic             busy
);
	int k;
	// Field 2 code, field 1 code, start code, two words, end code in blanking, two words
	localparam logic [7:0] VID_WORDS [20] = '{8'hFF, 8'h00, 8'h00, 8'h40, 8'hFF, 8'h00,
		8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h11, 8'h22, 8'hFF, 8'h00, 8'h00,
		8'h30, 8'h33, 8'h44};
	// Idle at time zero, clock parked low
	initial begin
		port_clk = 1'b0;
		fs = 3'h0;
		data = 16'h0000;
		busy = 1'b0;
	end
	// Burst: fs1 only in first period, data set while clock low
	always @(posedge go) begin
		busy = 1'b1;
		for (k = 0; k < edges; k++) begin
			fs[0] = (k == 0);
			data = vid ? {8'h00, VID_WORDS[k % 20]} : base + 16'(k);
			#160 port_clk = 1'b1;
			#160 port_clk = 1'b0;
		end
		fs[0] = 1'b0;
		// Released bus shows no stale value
		data = ~data;
		busy = 1'b0;
	end
endmodule : pvp_source_model

// File: tb.sv
`timescale 1ns/10ps
`include "pvp_defines.svh"
module tb
	import pvp_pkg::*;
;
	typedef struct {
		logic [15:0] dly;
		logic [15:0] cnt;
		logic [3:0]  wl;
		logic [15:0] base;
	} row_t;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic        wvalid = 1'b0;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        go = 1'b0;
	logic        vid = 1'b0;
	logic        tx_valid = 1'b1;
	logic [15:0] fld_exp[8] = '{16'h00FF, 16'h0000, 16'h0000, 16'h0000, 16'h0011,
		16'h0022, 16'h00FF, 16'h0000};
	logic [7:0]  edges = 8'h00;
	logic [15:0] base = 16'h0000;
	logic        awready, wready, bvalid, arready, rvalid, rx_valid, tx_ready, field_lock;
	logic        pclk, busy, port_data_oe;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, rd;
	logic [2:0]  fs_in, frame_sync_out, frame_sync_oe;
	logic [15:0] pdata, port_data_out, rx_data, m;
	logic [15:0] got[$];
	int          err_total = 0;
	int          compares = 0;
	row_t        rows[3] = '{'{16'h0, 16'h3, 4'h7, 16'h12F0},
		'{16'h2, 16'h4, 4'hF, 16'hABC0}, '{16'h1, 16'h2, 4'h9, 16'hFFF8}};
	// 25 MHz system clock
	always #20 aclk = ~aclk;
	pvp_source_model src (.go(go), .vid(vid), .edges(edges), .base(base), .port_clk(pclk),
		.fs(fs_in), .data(pdata), .busy(busy));
	parallel_video_port DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(1'b1), .port_sample_clock(pclk),
		.frame_sync_in(fs_in), .frame_sync_out(frame_sync_out),
		.frame_sync_oe(frame_sync_oe), .port_data_in(pdata),
		.port_data_out(port_data_out), .port_data_oe(port_data_oe), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(1'b1), .tx_data(16'h5A5A), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .field_lock(field_lock));
	// ****************************************
	// Helpers
	// ****************************************
	// Collect every sample taken off the stream
	always @(posedge aclk) begin
		if (aresetn && rx_valid === 1'b1)
			got.push_back(rx_data);
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Response channels kept ready, so only valid matters here
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
	endtask : wr
	task automatic rdreg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask : rdreg
	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask : do_reset
	// One source burst of n port edges, then let the stream drain
	task automatic burst(input logic [7:0] n);
		got.delete();
		edges <= n;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		repeat (2) @(posedge aclk);
		while (busy) @(posedge aclk);
		repeat (10) @(posedge aclk);
	endtask : burst
	task automatic test_done();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	// Whole run is well under this span
	initial begin
		#2000000;
		err_total++;
		test_done();
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		do_reset();
		// Input bursts: delay, exact count, width masking
		foreach (rows[i]) begin
			wr(`PVP_OFS_DELAY, {16'h0, rows[i].dly}, resp);
			wr(`PVP_OFS_COUNT, {16'h0, rows[i].cnt}, resp);
			wr(`PVP_OFS_CTRL, {24'h0, rows[i].wl, MODE_GP_IN, 1'b1}, resp);
			chk(frame_sync_oe, 3'h0);
			chk(port_data_oe, 1'b0);
			base <= rows[i].base;
			// Two extra edges must not add samples
			burst(8'(rows[i].dly + rows[i].cnt + 16'd3));
			m = (16'h0001 << (rows[i].wl + 5'd1)) - 16'h0001;
			chk(got.size(), rows[i].cnt);
			foreach (got[j])
				chk(got[j], (rows[i].base + rows[i].dly + 16'd1 + 16'(j)) & m);
			$display("burst %0d done", i);
		end
		// Sync and data directions per submode
		wr(`PVP_OFS_CTRL, {24'h0, 4'h7, MODE_GP_CAP, 1'b1}, resp);
		chk(frame_sync_oe, 3'h3);
		chk(port_data_oe, 1'b0);
		wr(`PVP_OFS_CTRL, {21'h0, 2'h3, 1'b0, 4'h7, MODE_GP_OUT, 1'b1}, resp);
		chk(frame_sync_oe, 3'h7);
		chk(port_data_oe, 1'b1);
		wr(`PVP_OFS_CTRL, {21'h0, 2'h2, 1'b0, 4'h7, MODE_GP_OUT, 1'b1}, resp);
		chk(frame_sync_oe, 3'h3);
		wr(`PVP_OFS_CTRL, {21'h0, 2'h1, 1'b0, 4'h7, MODE_GP_OUT, 1'b1}, resp);
		chk(frame_sync_oe, 3'h1);
		// Registered sync levels settle one edge after the write
		@(posedge aclk);
		chk(frame_sync_out, 3'h7);
		$display("directions done");
		// Output submode: sent word masked, missing word drives zero
		burst(8'd6);
		chk(port_data_out, 16'h005A);
		tx_valid <= 1'b0;
		burst(8'd6);
		chk(port_data_out, 16'h0000);
		rdreg(`PVP_OFS_STAT, rd, resp);
		chk(rd[1:0], 2'h2);
		wr(`PVP_OFS_STAT, 32'h3, resp);
		rdreg(`PVP_OFS_STAT, rd, resp);
		chk(rd[1:0], 2'h0);
		$display("output done");
		// Embedded-sync video: active, blanking, then entire field
		vid <= 1'b1;
		wr(`PVP_OFS_COUNT, 32'h1, resp);
		wr(`PVP_OFS_CTRL, {24'h0, 4'h7, MODE_V_ACT, 1'b1}, resp);
		burst(8'd20);
		chk(got.size(), 2);
		chk(got[0], 16'h0011);
		chk(got[1], 16'h0022);
		chk(field_lock, 1'b0);
		wr(`PVP_OFS_CTRL, {24'h0, 4'h7, MODE_V_VBI, 1'b1}, resp);
		burst(8'd24);
		chk(got.size(), 2);
		chk(got[0], 16'h0033);
		chk(got[1], 16'h0044);
		wr(`PVP_OFS_CTRL, 32'h0, resp);
		wr(`PVP_OFS_CTRL, {24'h0, 4'h7, MODE_V_FLD, 1'b1}, resp);
		burst(8'd20);
		chk(field_lock, 1'b1);
		chk(got.size(), 8);
		foreach (got[j])
			chk(got[j], fld_exp[j]);
		$display("video done");
		// Reset in mid-run, then register reset values
		do_reset();
		chk(field_lock, 1'b0);
		for (int a = 0; a < 5; a++) begin
			rdreg(8'(a * 4), rd, resp);
			chk(rd, (a == 2 || a == 3) ? 32'h1 : 32'h0);
			chk(resp, `PVP_RESP_OKAY);
		end
		// Unmapped place is refused both ways
		wr(8'h14, 32'hFFFFFFFF, resp);
		chk(resp, `PVP_RESP_ERR);
		rdreg(8'h14, rd, resp);
		chk(rd, 32'h0);
		chk(resp, `PVP_RESP_ERR);
		$display("registers done");
		test_done();
	end
endmodule : tb
